// >>> eeprom_pkg.sv
// constants, opcodes and state types shared by both ends of the serial eeprom link
// assumes a 100 MHz system clock on both ends
package eeprom_pkg;
    // array geometry
    localparam int ADDR_W_DEF      = 13;
    localparam int ADDR_W_MIN      = 10;
    localparam int ADDR_W_MAX      = 13;
    localparam int PAGE_W          = 5;
    localparam int PAGE_BYTES      = 32;
    // opcodes after bit 3 is masked off
    localparam logic [7:0] OP_MASK   = 8'hF7;
    localparam logic [7:0] OP_SET_WL = 8'h06;
    localparam logic [7:0] OP_CLR_WL = 8'h04;
    localparam logic [7:0] OP_RD_ST  = 8'h05;
    localparam logic [7:0] OP_WR_ST  = 8'h01;
    localparam logic [7:0] OP_READ   = 8'h03;
    localparam logic [7:0] OP_WRITE  = 8'h02;
    // status byte layout
    localparam int ST_HWPE_BIT     = 7;
    localparam int ST_BP_HI_BIT    = 3;
    localparam int ST_BP_LO_BIT    = 2;
    localparam int ST_WEL_BIT      = 1;
    localparam int ST_BUSY_BIT     = 0;
    localparam logic [7:0] ST_BUSY_VAL = 8'hFF;
    // block protect codes
    localparam logic [1:0] BP_NONE    = 2'h0;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam logic [1:0] BP_HALF    = 2'h2;
    localparam logic [1:0] BP_ALL     = 2'h3;
    localparam logic [1:0] BP_RST     = 2'h0;
    // timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int WRITE_TIME_MS     = 5;
    localparam int WRITE_CYCLES_DEF  = WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SCK_HALF_NS       = 170;
    localparam int SCK_HALF_CYCLES   = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // host controller register map (byte addresses)
    localparam logic [3:0] REG_DATA  = 4'h0;
    localparam logic [3:0] REG_CTRL  = 4'h4;
    localparam logic [3:0] REG_STAT  = 4'h8;
    localparam int CTRL_HOLD_BIT     = 0;
    localparam int CTRL_WP_BIT       = 1;
    localparam logic [1:0] CTRL_RST  = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD  = 3'b001,
        ST_ADDR = 3'b011,
        ST_DATA = 3'b010,
        ST_OUT  = 3'b110,
        ST_SKIP = 3'b100
    } dev_state_t;

    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_LOW  = 2'b01,
        H_HIGH = 2'b11
    } host_state_t;
endpackage : eeprom_pkg

// >>> spi_link_if.sv
// serial link between the eeprom device end and the host controller end
// the data output wire is pulled high while nobody drives it
interface spi_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
    logic so;
    logic so_oe;
    logic so_line;

    assign so_line = so_oe ? so : 1'b1;

    modport dev (input cs_n, input sck, input si, input wp_n, output so, output so_oe);
    modport host (output cs_n, output sck, output si, output wp_n, input so_line);
endinterface : spi_link_if

// >>> pin_sync.sv
// two-flop synchroniser with edge detection for pins from another domain
// assumes pins change no faster than a few system clocks, reset lasts three or more
module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,  // system clock
    input  wire logic         sys_rst_in,  // synchronous reset, high
    input  wire logic [W-1:0] pins_in,     // asynchronous pins
    output logic      [W-1:0] level_out,   // synchronised level
    output logic      [W-1:0] rise_out,    // one-cycle rising pulse
    output logic      [W-1:0] fall_out     // one-cycle falling pulse
);
    logic [W-1:0] meta;
    logic [W-1:0] last;

    // the chain keeps sampling through reset, so idle-high pins show no false edge
    always_ff @(posedge sys_clk_in) begin
        meta      <= pins_in;
        level_out <= meta;
        last      <= level_out;
    end

    // edges are masked while reset holds the consumers
    assign rise_out = level_out & ~last & ~{W{sys_rst_in}};
    assign fall_out = ~level_out & last & ~{W{sys_rst_in}};
endmodule : pin_sync

// >>> spi_eeprom_dev.sv
// serial eeprom device end: command decode, protection, array and write cycle
// assumes host drives chip select, serial clock and data in mode 0 or 3
// Summary of operation
// - block protect code guards top quarter/half/all
// - hardware protect only when pin low, enable set
// - hardware protect blocks every status write
// - enable bit cannot clear while pin low
// - array programs only with latch set, unprotected
// - write without latch ignored until next select
// - read: opcode, 16-bit address, byte out msb-first
// - read address increments after each byte
// - read address wraps top to bottom
// - host ends single read after one byte
// - busy cycle ignores all but read-status
// - host sends opcode, address, then data bytes
// - programming starts only at select release
// - host releases select in low phase after D0
// - status bit 0 shows write in progress
// - page write increments low five address bits
// - over 32 bytes wraps and overwrites page
// - write cycle end clears write latch
// - 8-bit opcodes, bit 3 ignored
// - status layout, all ones while busy
// - invalid opcode: ignore input, output off
//
// The address map and the Avalon-MM register port were left to the implementer.
module spi_eeprom_dev #(
    parameter int ADDR_W       = eeprom_pkg::ADDR_W_DEF,
    parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES_DEF
) (
    input  wire logic sys_clk_in,  // system clock
    input  wire logic sys_rst_in,  // synchronous reset, high
    spi_link_if.dev   link_if      // serial link, device side
);
    import eeprom_pkg::*;

    localparam int TW = $clog2(WRITE_CYCLES + 1);

    if (ADDR_W < ADDR_W_MIN || ADDR_W > ADDR_W_MAX || WRITE_CYCLES < 1) begin : g_bad
        $error("spi_eeprom_dev: unsupported parameter value");
    end

    logic [3:0]        lvl;
    logic [3:0]        rise;
    logic [3:0]        fall;
    dev_state_t        state;
    logic [6:0]        rx_sh;
    logic [2:0]        bit_cnt;
    logic [2:0]        obit;
    logic [7:0]        addr_hi;
    logic              addr_phase;
    logic              is_rd;
    logic              is_stat;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        out_sh;
    logic              wen;
    logic              hwpe;
    logic [1:0]        bp;
    logic              busy;
    logic              do_stat;
    logic [TW-1:0]     timer;
    logic [7:0]        st_new;
    logic              st_pend;
    logic [7:0]        pbuf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pmask;
    logic [7:0]        mem [2**ADDR_W];

    pin_sync #(
        .W (4)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .pins_in    ({link_if.cs_n, link_if.sck, link_if.si, link_if.wp_n}),
        .level_out  (lvl),
        .rise_out   (rise),
        .fall_out   (fall)
    );

    wire               cs_n_s   = lvl[3];
    wire               cs_fall  = fall[3];
    wire               cs_rise  = rise[3];
    wire               sck_rise = rise[2];
    wire               sck_fall = fall[2];
    wire               si_s     = lvl[1];
    wire               wp_n_s   = lvl[0];
    wire [7:0]         rx_byte  = {rx_sh, si_s};
    wire [7:0]         op       = rx_byte & OP_MASK;
    wire [15:0]        full_adr = {addr_hi, rx_byte};
    wire [ADDR_W-1:0]  new_addr = full_adr[ADDR_W-1:0];
    wire [ADDR_W-1:0]  next_addr = addr + ADDR_W'(1);
    wire [PAGE_W-1:0]  pidx     = addr[PAGE_W-1:0];
    wire               hw_prot  = ~wp_n_s & hwpe;
    wire               wc_done  = busy && (timer == '0);

    // status byte, all ones while the write cycle runs
    wire [7:0] status_byte = busy ? ST_BUSY_VAL :
        {hwpe, 3'h0, bp, wen, 1'b0};

    // true when an address lies in the block-protected region
    function automatic logic in_prot(input logic [ADDR_W-1:0] a, input logic [1:0] code);
        logic r;
        r = 1'b0;
        case (code)
            BP_QUARTER: r = (a[ADDR_W-1 -: 2] == 2'h3);
            BP_HALF:    r = a[ADDR_W-1];
            BP_ALL:     r = 1'b1;
            default:    r = 1'b0;
        endcase
        return r;
    endfunction : in_prot

    // serial command engine
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state      <= ST_IDLE;
            rx_sh      <= '0;
            bit_cnt    <= '0;
            obit       <= '0;
            addr_hi    <= '0;
            addr_phase <= 1'b0;
            is_rd      <= 1'b0;
            is_stat    <= 1'b0;
            addr       <= '0;
            out_sh     <= '0;
            link_if.so    <= 1'b0;
            link_if.so_oe <= 1'b0;
            wen        <= 1'b0;
            st_new     <= '0;
            st_pend    <= 1'b0;
            pmask      <= '0;
        end else begin
            if (cs_fall) begin
                state   <= ST_CMD;
                bit_cnt <= '0;
                if (!busy) begin
                    pmask   <= '0;
                    st_pend <= 1'b0;
                end
            end else if (cs_n_s) begin
                state         <= ST_IDLE;
                link_if.so_oe <= 1'b0;
            end else if (sck_rise) begin
                rx_sh   <= rx_byte[6:0];
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    case (state)
                        ST_CMD: begin
                            if (busy && op != OP_RD_ST) begin
                                state <= ST_SKIP;
                            end else begin
                                case (op)
                                    OP_SET_WL: begin
                                        wen   <= 1'b1;
                                        state <= ST_SKIP;
                                    end
                                    OP_CLR_WL: begin
                                        wen   <= 1'b0;
                                        state <= ST_SKIP;
                                    end
                                    OP_RD_ST: begin
                                        is_stat <= 1'b1;
                                        out_sh  <= status_byte;
                                        obit    <= '0;
                                        state   <= ST_OUT;
                                    end
                                    OP_WR_ST: begin
                                        is_stat <= 1'b1;
                                        state   <= wen ? ST_DATA : ST_SKIP;
                                    end
                                    OP_READ: begin
                                        is_rd      <= 1'b1;
                                        is_stat    <= 1'b0;
                                        addr_phase <= 1'b0;
                                        state      <= ST_ADDR;
                                    end
                                    OP_WRITE: begin
                                        is_rd      <= 1'b0;
                                        is_stat    <= 1'b0;
                                        addr_phase <= 1'b0;
                                        state      <= wen ? ST_ADDR : ST_SKIP;
                                    end
                                    default: state <= ST_SKIP;
                                endcase
                            end
                        end
                        ST_ADDR: begin
                            addr_phase <= 1'b1;
                            addr_hi    <= rx_byte;
                            if (addr_phase) begin
                                addr <= new_addr;
                                if (is_rd) begin
                                    out_sh <= mem[new_addr];
                                    obit   <= '0;
                                    state  <= ST_OUT;
                                end else begin
                                    state <= ST_DATA;
                                end
                            end
                        end
                        ST_DATA: begin
                            if (is_stat) begin
                                st_new  <= rx_byte;
                                st_pend <= 1'b1;
                            end else begin
                                pbuf[pidx]  <= rx_byte;
                                pmask[pidx] <= ~in_prot(addr, bp);
                                addr[PAGE_W-1:0] <= pidx + PAGE_W'(1);
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (sck_fall && state == ST_OUT) begin
                link_if.so    <= out_sh[7];
                link_if.so_oe <= 1'b1;
                out_sh        <= {out_sh[6:0], 1'b0};
                obit          <= obit + 3'h1;
                if (obit == 3'h7) begin
                    if (is_stat) begin
                        out_sh <= status_byte;
                    end else begin
                        addr   <= next_addr;
                        out_sh <= mem[next_addr];
                    end
                end
            end
            if (wc_done) begin
                wen <= 1'b0;
            end
        end
    end

    // self-timed write cycle and the nonvolatile status bits
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            busy    <= 1'b0;
            do_stat <= 1'b0;
            timer   <= '0;
            hwpe    <= 1'b0;
            bp      <= BP_RST;
        end else if (!busy) begin
            // only whole bytes at select release start a cycle
            if (cs_rise && state == ST_DATA && bit_cnt == 3'h0) begin
                if (st_pend ? !hw_prot : |pmask) begin
                    busy    <= 1'b1;
                    do_stat <= st_pend;
                    timer   <= TW'(WRITE_CYCLES - 1);
                end
            end
        end else if (wc_done) begin
            busy <= 1'b0;
            if (do_stat) begin
                hwpe <= st_new[ST_HWPE_BIT];
                bp   <= st_new[ST_BP_HI_BIT:ST_BP_LO_BIT];
            end
        end else begin
            timer <= timer - TW'(1);
        end
    end

    // array update at the end of the write cycle
    always_ff @(posedge sys_clk_in) begin
        if (wc_done && !do_stat) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pmask[i]) begin
                    mem[{addr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= pbuf[i];
                end
            end
        end
    end
endmodule : spi_eeprom_dev

// >>> spi_host_ctrl.sv
// host end: byte-wide serial master with an avalon-mm register port
// assumes software sequences opcodes, address and data bytes itself
module spi_host_ctrl #(
    parameter int HALF = eeprom_pkg::SCK_HALF_CYCLES
) (
    input  wire logic        sys_clk_in,           // system clock
    input  wire logic        sys_rst_in,           // synchronous reset, high
    input  wire logic [3:0]  avs_address_in,       // byte address
    input  wire logic        avs_read_in,          // read request
    input  wire logic        avs_write_in,         // write request
    input  wire logic [31:0] avs_writedata_in,     // write data
    output logic      [31:0] avs_readdata_out,     // read data
    output logic             avs_waitrequest_out,  // stall
    spi_link_if.host         link_if               // serial link, host side
);
    import eeprom_pkg::*;

    localparam int CW = $clog2(HALF + 1);

    if (HALF < 6) begin : g_bad
        $error("spi_host_ctrl: half period too short for pin synchronisers");
    end

    host_state_t hstate;
    logic [CW-1:0] cnt;
    logic [2:0]    bits;
    logic [7:0]    tx_sh;
    logic [7:0]    rx_sh;
    logic [1:0]    ctrl;
    logic          so_s;

    pin_sync #(
        .W (1)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .pins_in    (link_if.so_line),
        .level_out  (so_s),
        .rise_out   (),
        .fall_out   ()
    );

    wire shifting = (hstate != H_IDLE);
    wire req      = avs_read_in | avs_write_in;
    wire can      = !(avs_write_in && avs_address_in == REG_DATA && shifting);
    wire take     = !avs_waitrequest_out && avs_write_in;
    wire start    = take && avs_address_in == REG_DATA;

    // avalon slave: one cycle stall, effect at the edge waitrequest is seen low
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= '0;
            ctrl                <= CTRL_RST;
        end else if (avs_waitrequest_out) begin
            if (req && can) begin
                avs_waitrequest_out <= 1'b0;
                if (avs_address_in == REG_DATA) begin
                    avs_readdata_out <= {24'h0, rx_sh};
                end else if (avs_address_in == REG_CTRL) begin
                    avs_readdata_out <= {30'h0, ctrl};
                end else if (avs_address_in == REG_STAT) begin
                    avs_readdata_out <= {30'h0, ~link_if.cs_n, shifting};
                end else begin
                    avs_readdata_out <= '0;
                end
            end
        end else begin
            avs_waitrequest_out <= 1'b1;
            if (take && avs_address_in == REG_CTRL) begin
                ctrl <= avs_writedata_in[1:0];
            end
        end
    end

    // byte shifter, mode 0: data out before the rising edge, sampled on it
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            hstate       <= H_IDLE;
            cnt          <= '0;
            bits         <= '0;
            tx_sh        <= '0;
            rx_sh        <= '0;
            link_if.cs_n <= 1'b1;
            link_if.sck  <= 1'b0;
            link_if.si   <= 1'b0;
            link_if.wp_n <= 1'b1;
        end else begin
            link_if.wp_n <= ctrl[CTRL_WP_BIT];
            case (hstate)
                H_IDLE: begin
                    if (start) begin
                        link_if.cs_n <= 1'b0;
                        link_if.si   <= avs_writedata_in[7];
                        tx_sh        <= avs_writedata_in[7:0];
                        bits         <= '0;
                        cnt          <= CW'(HALF - 1);
                        hstate       <= H_LOW;
                    end else if (!ctrl[CTRL_HOLD_BIT]) begin
                        link_if.cs_n <= 1'b1;
                    end
                end
                H_LOW: begin
                    cnt <= cnt - CW'(1);
                    if (cnt == '0) begin
                        link_if.sck <= 1'b1;
                        rx_sh       <= {rx_sh[6:0], so_s};
                        cnt         <= CW'(HALF - 1);
                        hstate      <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    cnt <= cnt - CW'(1);
                    if (cnt == '0) begin
                        link_if.sck <= 1'b0;
                        cnt         <= CW'(HALF - 1);
                        if (bits == 3'h7) begin
                            hstate <= H_IDLE;
                        end else begin
                            bits       <= bits + 3'h1;
                            tx_sh      <= {tx_sh[6:0], 1'b0};
                            link_if.si <= tx_sh[6];
                            hstate     <= H_LOW;
                        end
                    end
                end
                default: hstate <= H_IDLE;
            endcase
        end
    end
endmodule : spi_host_ctrl

// >>> spi_link_checker.sv
// checker on the serial link wires between the host and device ends
// assumes the host half period of 6 system clocks
module spi_link_checker (
    input wire logic sys_clk_in, // system clock
    input wire logic sys_rst_in, // synchronous reset, high
    input wire logic cs_n_in,    // chip select, low active
    input wire logic sck_in,     // serial clock
    input wire logic si_in,      // host data
    input wire logic so_in,      // device data
    input wire logic so_oe_in    // device drive enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    logic       sck_q;
    logic [2:0] edges;
    always_ff @(posedge sys_clk_in) sck_q <= sck_in;
    // clock rises seen in this frame, modulo one byte
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || cs_n_in) begin
            edges <= 3'h0;
        end else if (sck_in && !sck_q) begin
            edges <= edges + 3'h1;
        end
    end
    AST_CS_WHOLE_BYTES: assert property ($rose(cs_n_in) |-> edges == 3'h0)
        else $error("select released mid byte");
    AST_CS_RISE_SCK_LOW: assert property ($rose(cs_n_in) |-> !sck_in)
        else $error("select released with clock high");
    AST_CS_FALL_SCK_LOW: assert property ($fell(cs_n_in) |-> !sck_in)
        else $error("select taken with clock high");
    AST_SI_HELD: assert property (sck_in && $past(sck_in) |-> $stable(si_in))
        else $error("host data moved while clock high");
    AST_SCK_HALF: assert property ($rose(sck_in) |-> sck_in [*6])
        else $error("clock high phase too short");
    AST_SO_HELD: assert property (so_oe_in && sck_in && $past(sck_in) |-> $stable(so_in))
        else $error("device data moved while clock high");
    AST_OE_SELECTED: assert property ($rose(so_oe_in) |-> !cs_n_in && !sck_in)
        else $error("device drove output when not due");
    AST_SO_OFF: assert property ($rose(cs_n_in) |-> ##[1:6] !so_oe_in)
        else $error("device output not released");
endmodule : spi_link_checker

// >>> test_spi_eeprom_protect_rw.sv
// bench: host controller drives the device end over the serial link
// assumes the host register map of the package and a 100 MHz clock
module test_spi_eeprom_protect_rw;
    timeunit 1ns;
    timeprecision 100ps;
    import eeprom_pkg::*;
    logic        clk;
    logic        rst;
    logic [3:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        wreq;
    logic [31:0] got;
    logic        wp;
    logic [7:0]  rx[$];
    logic [7:0]  q[$];
    int          n_errors;
    int          checked;
    int          cyc;
    spi_link_if link ();
    spi_eeprom_dev #(.WRITE_CYCLES(1500)) u_spi_eeprom_dev (.sys_clk_in(clk),
        .sys_rst_in(rst), .link_if(link));
    spi_host_ctrl #(.HALF(6)) u_spi_host_ctrl (.sys_clk_in(clk), .sys_rst_in(rst),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .link_if(link));
    spi_link_checker u_spi_link_checker (.sys_clk_in(clk), .sys_rst_in(rst),
        .cs_n_in(link.cs_n), .sck_in(link.sck), .si_in(link.si), .so_in(link.so),
        .so_oe_in(link.so_oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic results;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    always @(posedge clk) begin
        cyc++;
        if (cyc == 95000) begin
            n_errors++;
            results;
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d);
        addr  <= a;
        rd    <= ~w;
        wr    <= w;
        wdata <= d;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        got = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus
    // one select frame; received bytes land in rx
    task automatic frame(input logic [7:0] tx[$]);
        rx = {};
        bus(REG_CTRL, 1'b1, {30'h0, wp, 1'b1});
        foreach (tx[i]) begin
            bus(REG_DATA, 1'b1, {24'h0, tx[i]});
            do bus(REG_STAT, 1'b0, 32'h0); while (got[0] !== 1'b0);
            bus(REG_DATA, 1'b0, 32'h0);
            rx.push_back(got[7:0]);
        end
        bus(REG_CTRL, 1'b1, {30'h0, wp, 1'b0});
        repeat (4) @(posedge clk);
    endtask : frame
    task automatic st(input logic [7:0] e);
        frame({OP_RD_ST, 8'h00});
        chk(rx[1], e);
    endtask : st
    task automatic idle;
        do frame({OP_RD_ST, 8'h00}); while (rx[1][0] !== 1'b0);
    endtask : idle
    task automatic rdb(input logic [15:0] a, input logic [7:0] e);
        frame({OP_READ, a[15:8], a[7:0], 8'h00});
        chk(rx[3], e);
    endtask : rdb
    task automatic wrb(input logic [15:0] a, input logic [7:0] d);
        frame({OP_SET_WL});
        frame({OP_WRITE, a[15:8], a[7:0], d});
        idle;
    endtask : wrb
    task automatic wrst(input logic [7:0] v);
        frame({OP_SET_WL});
        frame({OP_WR_ST, v});
        idle;
    endtask : wrst
    initial begin
        {rst, wp, addr, rd, wr, wdata, n_errors, checked, cyc} = '1;
        {addr, rd, wr, wdata, n_errors, checked, cyc} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(REG_CTRL, 1'b0, 32'h0);
        chk(got[7:0], {6'h0, CTRL_RST});
        bus(4'hC, 1'b0, 32'h0);
        chk(got[7:0], 8'h00);
        st(8'h00);
        frame({8'h0E});
        st(8'h02);
        frame({8'h0C});
        st(8'h00);
        frame({8'h80, 8'h00});
        chk(rx[1], 8'hFF);
        frame({OP_WRITE, 8'h00, 8'h00, 8'h5A});
        st(8'h00);
        $display("test latch done");
        frame({OP_SET_WL});
        frame({OP_WRITE, 8'h00, 8'h00, 8'hA5});
        st(8'hFF);
        frame({OP_WRITE, 8'h00, 8'h00, 8'h3C});
        idle;
        st(8'h00);
        rdb(16'hE000, 8'hA5);
        $display("test write done");
        q = {OP_WRITE, 8'h1F, 8'hFE};
        for (int i = 0; i < 34; i++) q.push_back(8'(i));
        frame({OP_SET_WL});
        frame(q);
        idle;
        frame({OP_READ, 8'h1F, 8'hFE, 8'h00, 8'h00, 8'h00});
        chk(rx[3], 8'h20);
        chk(rx[4], 8'h21);
        chk(rx[5], 8'hA5);
        rdb(16'h1FE0, 8'h02);
        $display("test page done");
        for (int k = 0; k < 4; k++) begin
            wrst({4'h0, 2'(k), 2'h0});
            st({4'h0, 2'(k), 2'h0});
            wrb(16'h17FF, 8'h10 + 8'(k));
            wrb(16'h1800, 8'h20 + 8'(k));
            rdb(16'h17FF, (k < 2) ? 8'h10 + 8'(k) : 8'h11);
            rdb(16'h1800, 8'h20);
        end
        $display("test block done");
        wrst(8'h80);
        wp = 1'b0;
        wrst(8'h00);
        st(8'h82);
        wrb(16'h0000, 8'h77);
        rdb(16'h0000, 8'h77);
        wp = 1'b1;
        wrst(8'h00);
        st(8'h00);
        $display("test pin done");
        results;
    end
endmodule : test_spi_eeprom_protect_rw
